// ==== common/pcb_pkg.sv ====
// Package: constants and types shared by the power-on configuration register bank
package pcb_pkg;

	// ==========================================================
	// Bus geometry
	localparam int PCB_ADDR_W = 12;
	localparam int PCB_DATA_W = 64;

	// ==========================================================
	// Register addresses (register index as seen by software)
	localparam logic [PCB_ADDR_W-1:0] PCB_ADDR_POWERON = 12'h02a;
	localparam logic [PCB_ADDR_W-1:0] PCB_ADDR_TESTCTL = 12'h033;
	localparam logic [PCB_ADDR_W-1:0] PCB_ADDR_UPDTRIG = 12'h079;
	localparam logic [PCB_ADDR_W-1:0] PCB_ADDR_CHUNK0 = 12'h088;
	localparam logic [PCB_ADDR_W-1:0] PCB_ADDR_CHUNK1 = 12'h089;

	// ==========================================================
	// Power-on configuration register fields
	localparam int PCB_PON_DATA_CHK = 1;
	localparam int PCB_PON_RESP_CHK = 2;
	localparam int PCB_PON_ADDRESS_ERROR_SIGNAL_DRV = 3;
	localparam int PCB_PON_BUS_ERROR_SIGNAL_INIT = 4;
	localparam int PCB_PON_BUS_ERROR_SIGNAL_INT = 6;
	localparam int PCB_PON_BUS_INIT_SIGNAL_DRV = 7;
	localparam int PCB_PON_IOQ_ONE = 13;
	localparam int PCB_PON_VEC_1M = 14;
	localparam int PCB_PON_FREQ_LO = 18;
	localparam int PCB_PON_LOW_PWR = 26;
	// Writable enables: bits 1,2,3,4,6,7,26
	localparam logic [PCB_DATA_W-1:0] PCB_PON_RW_MASK = 64'h0000_0000_0400_00de;
	// Strap-reported bits: 8,9,10,12..25,27
	localparam logic [PCB_DATA_W-1:0] PCB_PON_RO_MASK = 64'h0000_0000_0bff_f700;
	localparam logic [PCB_DATA_W-1:0] PCB_PON_RESET = 64'h0;

	// ==========================================================
	// Test control register fields
	localparam int PCB_TC_STREAM_DIS = 30;
	localparam int PCB_TC_LOCK_SPLIT = 31;
	localparam logic [31:0] PCB_TC_RW_MASK = 32'hc000_0000;
	localparam logic [31:0] PCB_TC_RESET = 32'h0;

	// ==========================================================
	// System bus frequency encodings
	localparam logic [1:0] PCB_FREQ_66 = 2'h0;
	localparam logic [1:0] PCB_FREQ_133 = 2'h1;
	localparam logic [1:0] PCB_FREQ_100 = 2'h2;
	localparam logic [1:0] PCB_FREQ_RSVD = 2'h3;

	// ==========================================================
	// Register selection decoded from the address
	typedef enum logic [2:0] {
		PCB_SEL_NONE = 3'h0,
		PCB_SEL_PON = 3'h1,
		PCB_SEL_TC = 3'h2,
		PCB_SEL_UPD = 3'h3,
		PCB_SEL_CHUNK = 3'h4
	} pcb_sel_e;

	// Strap capture states, Gray along the path
	typedef enum logic {
		PCB_ST_WAIT = 1'b0,
		PCB_ST_HELD = 1'b1
	} pcb_strap_e;

endpackage : pcb_pkg

// ==== design/pcb_chunk_mem.sv ====
// Small memory holding the L2 chunk data words, registered read port
`timescale 1ns/1ps
`default_nettype none
module pcb_chunk_mem #(
	parameter int WIDTH = 64,
	parameter int DEPTH = 2,
	parameter int IDX_W = 1
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Write port
	input wire logic wrEn,
	input wire logic [IDX_W-1:0] wrIdx,
	input wire logic [WIDTH-1:0] wrData,
	// Read port
	input wire logic rdEn,
	input wire logic [IDX_W-1:0] rdIdx,
	output logic [WIDTH-1:0] rdData
);

	// ==========================================================
	// Storage
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [WIDTH-1:0] mem_nxt [DEPTH];
	logic [WIDTH-1:0] rdData_r;
	logic [WIDTH-1:0] rdData_nxt;

	// Next values: write one word, capture read word on request
	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			mem_nxt[i] = mem_r[i];
		end
		if (wrEn) begin
			mem_nxt[wrIdx] = wrData;
		end
		rdData_nxt = rdEn ? mem_r[rdIdx] : rdData_r;
	end

	// Registers; cleared so a read before any write is defined
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= '0;
			end
			rdData_r <= '0;
		end else begin
			mem_r <= mem_nxt;
			rdData_r <= rdData_nxt;
		end
	end

	assign rdData = rdData_r;

endmodule : pcb_chunk_mem
`default_nettype wire

// ==== design/pcb_msr_bank.sv ====
// Power-on configuration register bank with test control, update trigger and L2 chunk data
`timescale 1ns/1ps
`default_nettype none

// Function
// - Configuration register accepts enable writes; reads return configuration now in effect.
// - Bit 1 read/write enables system bus data error checking.
// - Bit 2 read/write enables response checking and redundancy error observation.
// - Bit 4 read/write lets processor assert bus error for its requests.
// - Bit 6 read/write lets processor drive bus error for internal errors.
// - Bit 13 read-only in-order queue depth, 1 means one, 0 means eight.
// - Bit 14 read-only reset vector, 1 means 1 MB, 0 means 4 GB.
// - Field 19:18 reports bus frequency: 00=66, 10=100, 01=133, 11 reserved.
// - Bit 26 read/write enables low power mode.
// - Test control bit 31 set suppresses bus lock for split locked accesses.
// - Writing address 79H triggers a processor update.
// - Address 88 holds 64-bit L2 chunk 0 data, read and write.
// - Address 89 holds 64-bit L2 chunk 1 data, read and write.
module pcb_msr_bank
	import pcb_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Register port
	input wire logic [PCB_ADDR_W-1:0] regAddr,
	input wire logic [PCB_DATA_W-1:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [PCB_DATA_W-1:0] regRdData,
	// Power-on straps from pins, bit positions as in the configuration register
	input wire logic [PCB_DATA_W-1:0] strapPins,
	// Feature enables to the bus unit
	output logic dataErrCheckEn,
	output logic respErrCheckEn,
	output logic addrErrDriveEn,
	output logic busErrInitiatorEn,
	output logic busErrInternalEn,
	output logic busInitDriveEn,
	output logic lowPowerEn,
	// Test control outputs
	output logic streamBufDisable,
	output logic lockSplitSuppress,
	// Latched configuration
	output logic ioqDepthOne,
	output logic resetVec1M,
	output logic [1:0] busFreqCode,
	output logic strapsValid,
	// Update trigger
	output logic updateStart,
	output logic [PCB_DATA_W-1:0] updateData
);

	// ==========================================================
	// Address decode, shared by the write and read paths
	function automatic pcb_sel_e decodeSel(input logic [PCB_ADDR_W-1:0] a);
		unique case (a)
			PCB_ADDR_POWERON: decodeSel = PCB_SEL_PON;
			PCB_ADDR_TESTCTL: decodeSel = PCB_SEL_TC;
			PCB_ADDR_UPDTRIG: decodeSel = PCB_SEL_UPD;
			PCB_ADDR_CHUNK0, PCB_ADDR_CHUNK1: decodeSel = PCB_SEL_CHUNK;
			default: decodeSel = PCB_SEL_NONE;
		endcase
	endfunction : decodeSel

	pcb_sel_e wrSel;
	pcb_sel_e rdSel;
	assign wrSel = decodeSel(regAddr);
	assign rdSel = decodeSel(regAddr);

	// ==========================================================
	// Strap synchroniser and one-time capture
	logic [PCB_DATA_W-1:0] strapS1_r;
	logic [PCB_DATA_W-1:0] strapS2_r;
	logic [PCB_DATA_W-1:0] strapS3_r;
	logic [PCB_DATA_W-1:0] strapHeld_r;
	logic [PCB_DATA_W-1:0] strapHeld_nxt;
	pcb_strap_e strapSt_r;
	pcb_strap_e strapSt_nxt;
	// Fill chain: bit 2 set once the last stage holds real pin samples, not reset zeros
	logic [2:0] strapFill_r;
	logic [2:0] strapFill_nxt;

	// Capture once the last two stages agree; pins may settle late after power-up
	always_comb begin
		strapSt_nxt = strapSt_r;
		strapHeld_nxt = strapHeld_r;
		strapFill_nxt = {strapFill_r[1:0], 1'b1};
		unique case (strapSt_r)
			PCB_ST_WAIT: begin
				// Without the fill check the cleared stages would agree at once and latch zeros
				if (strapFill_r[2] && strapS2_r == strapS3_r) begin
					strapHeld_nxt = strapS3_r & PCB_PON_RO_MASK;
					strapSt_nxt = PCB_ST_HELD;
				end
			end
			PCB_ST_HELD: begin
				strapSt_nxt = PCB_ST_HELD;
			end
		endcase
	end

	// Straps are sampled only after release, never under the reset itself
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			strapS1_r <= '0;
			strapS2_r <= '0;
			strapS3_r <= '0;
			strapHeld_r <= '0;
			strapSt_r <= PCB_ST_WAIT;
			strapFill_r <= '0;
		end else begin
			strapS1_r <= strapPins;
			strapS2_r <= strapS1_r;
			strapS3_r <= strapS2_r;
			strapHeld_r <= strapHeld_nxt;
			strapSt_r <= strapSt_nxt;
			strapFill_r <= strapFill_nxt;
		end
	end

	// ==========================================================
	// Writable registers
	logic [PCB_DATA_W-1:0] ponRw_r;
	logic [PCB_DATA_W-1:0] ponRw_nxt;
	logic [31:0] testCtl_r;
	logic [31:0] testCtl_nxt;
	logic updStart_r;
	logic updStart_nxt;
	logic [PCB_DATA_W-1:0] updData_r;
	logic [PCB_DATA_W-1:0] updData_nxt;

	// Only documented enable bits are stored, so reserved writes are dropped
	always_comb begin
		ponRw_nxt = ponRw_r;
		testCtl_nxt = testCtl_r;
		updStart_nxt = 1'b0;
		updData_nxt = updData_r;
		if (regWr) begin
			unique case (wrSel)
				PCB_SEL_PON: ponRw_nxt = regWrData & PCB_PON_RW_MASK;
				PCB_SEL_TC: testCtl_nxt = regWrData[31:0] & PCB_TC_RW_MASK;
				PCB_SEL_UPD: begin
					updStart_nxt = 1'b1;
					updData_nxt = regWrData;
				end
				PCB_SEL_CHUNK, PCB_SEL_NONE: ponRw_nxt = ponRw_r;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ponRw_r <= PCB_PON_RESET;
			testCtl_r <= PCB_TC_RESET;
			updStart_r <= 1'b0;
			updData_r <= '0;
		end else begin
			ponRw_r <= ponRw_nxt;
			testCtl_r <= testCtl_nxt;
			updStart_r <= updStart_nxt;
			updData_r <= updData_nxt;
		end
	end

	// ==========================================================
	// L2 chunk data words
	logic [PCB_DATA_W-1:0] chunkRdData;

	pcb_chunk_mem #(
		.WIDTH(PCB_DATA_W),
		.DEPTH(2),
		.IDX_W(1)
	) u_chunk (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.wrEn(regWr && wrSel == PCB_SEL_CHUNK),
		.wrIdx(regAddr[0]),
		.wrData(regWrData),
		.rdEn(regRd && rdSel == PCB_SEL_CHUNK),
		.rdIdx(regAddr[0]),
		.rdData(chunkRdData)
	);

	// ==========================================================
	// Read path: value in effect now, presented one cycle after the strobe
	logic [PCB_DATA_W-1:0] ponView;
	logic [PCB_DATA_W-1:0] rdData_r;
	logic [PCB_DATA_W-1:0] rdData_nxt;
	logic rdChunk_r;
	logic rdChunk_nxt;

	assign ponView = ponRw_r | strapHeld_r;

	always_comb begin
		rdData_nxt = rdData_r;
		rdChunk_nxt = rdChunk_r;
		if (regRd) begin
			rdChunk_nxt = (rdSel == PCB_SEL_CHUNK);
			unique case (rdSel)
				PCB_SEL_PON: rdData_nxt = ponView;
				PCB_SEL_TC: rdData_nxt = {32'h0, testCtl_r};
				// Trigger is write-only; unmapped addresses read zero
				PCB_SEL_UPD, PCB_SEL_CHUNK, PCB_SEL_NONE: rdData_nxt = '0;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdData_r <= '0;
			rdChunk_r <= 1'b0;
		end else begin
			rdData_r <= rdData_nxt;
			rdChunk_r <= rdChunk_nxt;
		end
	end

	assign regRdData = rdChunk_r ? chunkRdData : rdData_r;

	// ==========================================================
	// Outputs, all straight from registers
	assign dataErrCheckEn = ponRw_r[PCB_PON_DATA_CHK];
	assign respErrCheckEn = ponRw_r[PCB_PON_RESP_CHK];
	assign addrErrDriveEn = ponRw_r[PCB_PON_ADDRESS_ERROR_SIGNAL_DRV];
	assign busErrInitiatorEn = ponRw_r[PCB_PON_BUS_ERROR_SIGNAL_INIT];
	assign busErrInternalEn = ponRw_r[PCB_PON_BUS_ERROR_SIGNAL_INT];
	assign busInitDriveEn = ponRw_r[PCB_PON_BUS_INIT_SIGNAL_DRV];
	assign lowPowerEn = ponRw_r[PCB_PON_LOW_PWR];
	assign streamBufDisable = testCtl_r[PCB_TC_STREAM_DIS];
	assign lockSplitSuppress = testCtl_r[PCB_TC_LOCK_SPLIT];
	assign ioqDepthOne = strapHeld_r[PCB_PON_IOQ_ONE];
	assign resetVec1M = strapHeld_r[PCB_PON_VEC_1M];
	assign busFreqCode = strapHeld_r[PCB_PON_FREQ_LO+1:PCB_PON_FREQ_LO];
	assign strapsValid = (strapSt_r == PCB_ST_HELD);
	assign updateStart = updStart_r;
	assign updateData = updData_r;

	// ==========================================================
	// Assertions
	sequence sqPonWr;
		regWr && regAddr == PCB_ADDR_POWERON;
	endsequence

	sequence sqPonRd;
		regRd && regAddr == PCB_ADDR_POWERON;
	endsequence

	AST_PON_READBACK: assert property (@(posedge sys_clk) disable iff (!arst_n)
		sqPonRd |=> regRdData == $past(ponRw_r | strapHeld_r))
		else $error("configuration read does not show value in effect");

	AST_DATA_CHK: assert property (@(posedge sys_clk) disable iff (!arst_n)
		sqPonWr |=> dataErrCheckEn == $past(regWrData[1]))
		else $error("data error check enable not taken from bit 1");

	AST_RESP_CHK: assert property (@(posedge sys_clk) disable iff (!arst_n)
		sqPonWr |=> respErrCheckEn == $past(regWrData[2]))
		else $error("response check enable not taken from bit 2");

	AST_BUS_ERROR_SIGNAL_INIT: assert property (@(posedge sys_clk) disable iff (!arst_n)
		sqPonWr |=> busErrInitiatorEn == $past(regWrData[4]))
		else $error("initiator bus error enable not taken from bit 4");

	AST_BUS_ERROR_SIGNAL_INT: assert property (@(posedge sys_clk) disable iff (!arst_n)
		sqPonWr |=> busErrInternalEn == $past(regWrData[6]))
		else $error("internal bus error enable not taken from bit 6");

	AST_STRAP_STABLE: assert property (@(posedge sys_clk) disable iff (!arst_n)
		strapsValid |=> $stable(ioqDepthOne) && $stable(resetVec1M) && $stable(busFreqCode))
		else $error("latched straps changed after capture");

	AST_STRAP_FIELDS: assert property (@(posedge sys_clk) disable iff (!arst_n)
		sqPonRd |=> regRdData[19:18] == busFreqCode && regRdData[13] == ioqDepthOne
			&& regRdData[14] == resetVec1M)
		else $error("strap fields in readback disagree with outputs");

	AST_LOW_PWR: assert property (@(posedge sys_clk) disable iff (!arst_n)
		sqPonWr ##1 (!regWr)[*2] |-> lowPowerEn == $past(regWrData[26], 2))
		else $error("low power enable lost or not taken from bit 26");

	AST_LOCK_SPLIT: assert property (@(posedge sys_clk) disable iff (!arst_n)
		regWr && regAddr == PCB_ADDR_TESTCTL |=> lockSplitSuppress == $past(regWrData[31]))
		else $error("split lock suppress not taken from bit 31");

	AST_UPD_PULSE: assert property (@(posedge sys_clk) disable iff (!arst_n)
		regWr && regAddr == PCB_ADDR_UPDTRIG |=> updateStart
			##1 (!updateStart || $past(regWr && regAddr == PCB_ADDR_UPDTRIG)))
		else $error("update trigger pulse missing or too long");

	AST_CHUNK_RT: assert property (@(posedge sys_clk) disable iff (!arst_n)
		regWr && regAddr == PCB_ADDR_CHUNK0 ##1 regRd && regAddr == PCB_ADDR_CHUNK0
		|=> regRdData == $past(regWrData, 2))
		else $error("chunk 0 read does not return written data");

	AST_CHUNK1_RT: assert property (@(posedge sys_clk) disable iff (!arst_n)
		regWr && regAddr == PCB_ADDR_CHUNK1 ##1 regRd && regAddr == PCB_ADDR_CHUNK1
		|=> regRdData == $past(regWrData, 2))
		else $error("chunk 1 read does not return written data");

	AST_RSVD_ZERO: assert property (@(posedge sys_clk) disable iff (!arst_n)
		sqPonRd |=> (regRdData & ~(PCB_PON_RW_MASK | PCB_PON_RO_MASK)) == '0)
		else $error("reserved configuration bits read nonzero");

endmodule : pcb_msr_bank
`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking testbench for the power-on configuration register bank
`timescale 1ns/1ps
`default_nettype none
module tb
	import pcb_pkg::*;
;
	// ==========================================================
	// Stimulus and observation signals
	logic sysClk = 1'b0;
	logic arstN = 1'b0;
	logic [PCB_ADDR_W-1:0] regAddr = '0;
	logic [PCB_DATA_W-1:0] regWrData = '0;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [PCB_DATA_W-1:0] regRdData;
	logic [PCB_DATA_W-1:0] strapPins = '0;
	logic dataErrCheckEn, respErrCheckEn, addrErrDriveEn, busErrInitiatorEn;
	logic busErrInternalEn, busInitDriveEn, lowPowerEn;
	logic streamBufDisable, lockSplitSuppress, ioqDepthOne, resetVec1M, strapsValid;
	logic [1:0] busFreqCode;
	logic updateStart;
	logic [PCB_DATA_W-1:0] updateData;
	logic [63:0] rdVal;
	logic [63:0] strapExp;
	int errCount = 0;
	int cmpCount = 0;
	// Enables in bit order 1,2,3,4,6,7,26 so one vector compare covers them all
	logic [6:0] enVec;
	assign enVec = {lowPowerEn, busInitDriveEn, busErrInternalEn, busErrInitiatorEn,
		addrErrDriveEn, respErrCheckEn, dataErrCheckEn};
	int pb[7] = '{1, 2, 3, 4, 6, 7, 26};

	// ==========================================================
	// Clock, 25 ns period
	always #12.5 sysClk = ~sysClk;

	pcb_msr_bank pcb_msr_bank_i (
		.sys_clk(sysClk), .arst_n(arstN), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .strapPins(strapPins),
		.dataErrCheckEn(dataErrCheckEn), .respErrCheckEn(respErrCheckEn),
		.addrErrDriveEn(addrErrDriveEn), .busErrInitiatorEn(busErrInitiatorEn),
		.busErrInternalEn(busErrInternalEn), .busInitDriveEn(busInitDriveEn),
		.lowPowerEn(lowPowerEn), .streamBufDisable(streamBufDisable),
		.lockSplitSuppress(lockSplitSuppress), .ioqDepthOne(ioqDepthOne),
		.resetVec1M(resetVec1M), .busFreqCode(busFreqCode), .strapsValid(strapsValid),
		.updateStart(updateStart), .updateData(updateData)
	);

	// ==========================================================
	// Reporting
	task automatic testDone();
		$display("Comparisons %0d, mismatches %0d", cmpCount, errCount);
		if (errCount == 0 && cmpCount > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : testDone

	// Four-state compare so an unknown never counts as a match
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		cmpCount++;
		if (got !== exp) begin
			errCount++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// ==========================================================
	// Register port tasks: one-cycle strobes, driven right after an edge
	task automatic wr(input logic [PCB_ADDR_W-1:0] a, input logic [63:0] d);
		@(posedge sysClk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge sysClk);
		regWr <= 1'b0;
	endtask : wr

	// Read data appear in the cycle after the strobe and hold until the next read, so sample just after that edge
	task automatic rd(input logic [PCB_ADDR_W-1:0] a, output logic [63:0] d);
		@(posedge sysClk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge sysClk);
		regRd <= 1'b0;
		#1;
		d = regRdData;
	endtask : rd

	task automatic rdChk(input logic [PCB_ADDR_W-1:0] a, input logic [63:0] exp);
		logic [63:0] d;
		rd(a, d);
		chk(d, exp);
	endtask : rdChk

	// Write then read the same register with no idle cycle between the strobes
	task automatic wrRdChk(input logic [PCB_ADDR_W-1:0] a, input logic [63:0] d);
		@(posedge sysClk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge sysClk);
		regWr <= 1'b0;
		regRd <= 1'b1;
		@(posedge sysClk);
		regRd <= 1'b0;
		#1;
		chk(regRdData, d);
	endtask : wrRdChk

	// Straps are sampled only while leaving reset, so every strap pattern needs a reset
	task automatic doReset(input logic [63:0] s);
		int n;
		@(posedge sysClk);
		strapPins <= s;
		arstN <= 1'b0;
		repeat (16) @(posedge sysClk);
		chk({57'h0, enVec}, 64'h0);
		arstN <= 1'b1;
		n = 0;
		while (strapsValid !== 1'b1 && n < 20) begin
			@(posedge sysClk);
			#1;
			n++;
		end
		if (strapsValid !== 1'b1) begin
			errCount++;
			$display("Error at %0t: strap latch got %h expected %h", $time, strapsValid, 1'b1);
			testDone();
		end
		strapExp = s & PCB_PON_RO_MASK;
	endtask : doReset

	// ==========================================================
	// Main sequence
	initial begin
		doReset(64'hffff_ffff_ffff_ffff);
		rdChk(PCB_ADDR_POWERON, PCB_PON_RO_MASK);
		chk({62'h0, ioqDepthOne, resetVec1M}, 64'h3);
		// Pins moving after power-on must not disturb the latched view
		@(posedge sysClk);
		strapPins <= 64'h0;
		rdChk(PCB_ADDR_POWERON, PCB_PON_RO_MASK);
		// Every enable on, then each one alone with all non-enable bits set as noise
		wr(PCB_ADDR_POWERON, 64'hffff_ffff_ffff_ffff);
		#1 chk({57'h0, enVec}, 64'h7f);
		rdChk(PCB_ADDR_POWERON, PCB_PON_RW_MASK | strapExp);
		for (int i = 0; i < 7; i++) begin
			wr(PCB_ADDR_POWERON, (64'h1 << pb[i]) | ~PCB_PON_RW_MASK);
			#1 chk({57'h0, enVec}, 64'h1 << i);
			rdChk(PCB_ADDR_POWERON, (64'h1 << pb[i]) | strapExp);
		end
		// Test control: only bits 31:30 hold
		wr(PCB_ADDR_TESTCTL, 64'hffff_ffff_ffff_ffff);
		rdChk(PCB_ADDR_TESTCTL, 64'h0000_0000_c000_0000);
		chk({62'h0, lockSplitSuppress, streamBufDisable}, 64'h3);
		wr(PCB_ADDR_TESTCTL, 64'h0000_0000_8000_0000);
		#1 chk({62'h0, lockSplitSuppress, streamBufDisable}, 64'h2);
		wr(PCB_ADDR_TESTCTL, 64'h0);
		#1 chk({63'h0, lockSplitSuppress}, 64'h0);
		// Update trigger: one-cycle pulse carrying the written word, reads back zero
		wr(PCB_ADDR_UPDTRIG, 64'h0123_4567_89ab_cdef);
		#1 chk({63'h0, updateStart}, 64'h1);
		chk(updateData, 64'h0123_4567_89ab_cdef);
		@(posedge sysClk);
		#1 chk({63'h0, updateStart}, 64'h0);
		rdChk(PCB_ADDR_UPDTRIG, 64'h0);
		// Chunk words are independent and keep full 64-bit values, read back with no gap
		wrRdChk(PCB_ADDR_CHUNK0, 64'hdead_beef_0bad_f00d);
		wrRdChk(PCB_ADDR_CHUNK1, 64'h5a5a_a5a5_1234_8765);
		rdChk(PCB_ADDR_CHUNK0, 64'hdead_beef_0bad_f00d);
		rdChk(PCB_ADDR_CHUNK1, 64'h5a5a_a5a5_1234_8765);
		// Unmapped neighbours are ignored, and 08a reads zero
		wr(12'h08a, 64'hffff_ffff_ffff_ffff);
		wr(12'h188, 64'h0);
		rdChk(12'h08a, 64'h0);
		rdChk(PCB_ADDR_CHUNK0, 64'hdead_beef_0bad_f00d);
		rdChk(PCB_ADDR_CHUNK1, 64'h5a5a_a5a5_1234_8765);
		// Every bus frequency code, with queue depth and vector straps alternating
		for (int f = 0; f < 4; f++) begin
			doReset((64'(f) << 18) | ((f % 2) ? 64'h2000 : 64'h4000) | 64'h0800_0100);
			chk({62'h0, busFreqCode}, 64'(f));
			chk({62'h0, ioqDepthOne, resetVec1M}, (f % 2) ? 64'h2 : 64'h1);
			rdChk(PCB_ADDR_POWERON, strapExp);
			rdChk(PCB_ADDR_CHUNK0, 64'h0);
		end
		testDone();
	end
endmodule : tb
`default_nettype wire
